// File: pkg/scit_consts.svh
/*
  named offsets, field positions, reset values and times of the system control unit.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef SCIT_CONSTS_SVH
`define SCIT_CONSTS_SVH

`define SCIT_CLK_MHZ 125
`define SCIT_MS_US 1000
`define SCIT_RST_PULSE_US 125
`define SCIT_WD_PERIOD_MS 128
`define SCIT_SOFT_RESET_REG_BCL_CYCLES 3'h4

`define SCIT_ADR_MASK 8'h20
`define SCIT_ADR_TOP_IRQ_STATUS 8'h21
`define SCIT_ADR_AUX_IRQ_STATUS 8'h22
`define SCIT_ADR_AUX_IRQ_MASK 8'h23
`define SCIT_ADR_FIRST_MODE_REG 8'h24
`define SCIT_ADR_SOFT_RESET_REG 8'h25
`define SCIT_ADR_WDOG 8'h26
`define SCIT_ADR_CFG 8'h27
`define SCIT_ADR_AUX_CONFIG_TWO 8'h28
`define SCIT_ADR_TIMER_CONTROL 8'h65

`define SCIT_TOP_IRQ_STATUS_MOS 0
`define SCIT_TOP_IRQ_STATUS_CIC 1
`define SCIT_TOP_IRQ_STATUS_TRAN 2
`define SCIT_TOP_IRQ_STATUS_ST 3
`define SCIT_TOP_IRQ_STATUS_AUX 4
`define SCIT_AUX_TIN 0
`define SCIT_AUX_WOV 1
`define SCIT_SOFT_RESET_REG_EXT 0
`define SCIT_WD_A 1
`define SCIT_WD_B 0
`define SCIT_CFG_POL 0
`define SCIT_AUX_CONFIG_TWO_SEL 0
`define SCIT_AUX_CONFIG_TWO_LED 1
`define SCIT_TMR_MODE 7
`define SCIT_TMR_CNT_HI 5

`define SCIT_RSS_NONE 2'h0
`define SCIT_RSS_SOFT 2'h1
`define SCIT_RSS_CIAW 2'h2
`define SCIT_RSS_WDOG 2'h3

`define SCIT_MASK_RST 5'h00
`define SCIT_AUX_IRQ_MASK_RST 2'h0
`define SCIT_FIRST_MODE_REG_RST 2'h0
`define SCIT_TIMER_CONTROL_RST 8'h00
`define SCIT_ZERO8 8'h00

`endif

// File: pkg/scit_pkg.sv
/*
  types of the system control unit.
  assumes the constants header is on the include path.
*/
package scit_pkg;
  `include "scit_consts.svh"

  typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} scit_pulse_t;
  typedef enum logic {WD_IDLE, WD_ARMED} scit_wdseq_t;
endpackage

// File: rtl/scit_sys_ctrl.sv
/*
  system control unit: interrupt gathering and masking, reset source selection and
  reset pulse, watchdog, self-clearing software resets, millisecond timer, led pin.
  assumes a decoded 8-bit register port from the serial host interface, all inputs
  synchronous to clock, bitClkEn a one-cycle strobe per bit clock period.
*/
`timescale 1ns/1ns
`include "scit_consts.svh"

module scit_sys_ctrl
  import scit_pkg::*;
#(
  parameter int SOFT_RESET_REG_W = 4,
  parameter int MS_CYCLES = `SCIT_CLK_MHZ * `SCIT_MS_US,
  parameter int PULSE_CYCLES = `SCIT_CLK_MHZ * `SCIT_RST_PULSE_US,
  parameter int WD_CYCLES = `SCIT_CLK_MHZ * `SCIT_MS_US * `SCIT_WD_PERIOD_MS
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic bitClkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic monitorHandlerIrq,
  input wire logic cmdIndChangeIrq,
  input wire logic tranIrq,
  input wire logic syncTransferIrq,
  input wire logic [3:0] downstreamCmdInd,
  input wire logic subscriberAwakeN,
  input wire logic layer1Activated,
  output logic irqOut,
  output logic resetOutN,
  output logic [SOFT_RESET_REG_W-1:0] blockReset,
  output logic oscWake,
  output logic activationLedN
);

  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int WDW = $clog2(WD_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [4:0] mask_r, mask_nxt;
  logic [1:0] auxStat_r, auxStat_nxt;
  logic [1:0] auxMask_r, auxMask_nxt;
  logic [1:0] rss_r, rss_nxt;
  logic [SOFT_RESET_REG_W-1:0] soft_reset_reg_r, soft_reset_reg_nxt;
  logic [2:0] sresCnt_r, sresCnt_nxt;
  logic polHigh_r, polHigh_nxt;
  logic ledSel_r, ledSel_nxt;
  logic ledBit_r, ledBit_nxt;
  logic [7:0] timer_control_r, timer_control_nxt;
  logic [MSW-1:0] msPre_r, msPre_nxt;
  logic [5:0] msCnt_r, msCnt_nxt;
  logic tmrDone_r, tmrDone_nxt;
  logic wdEn_r, wdEn_nxt;
  logic [WDW-1:0] wdCnt_r, wdCnt_nxt;
  scit_wdseq_t wdSeq_r, wdSeq_nxt;
  scit_pulse_t pulse_r, pulse_nxt;
  logic [PW-1:0] pulseCnt_r, pulseCnt_nxt;
  logic [3:0] ciPrev_r, ciPrev_nxt;
  logic awakePrev_r, awakePrev_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic irq_r, irq_nxt;
  logic rstOut_r, rstOut_nxt;
  logic led_r, led_nxt;
  logic wake_r, wake_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // combinational helpers
  logic [4:0] top_irq_status;
  logic wrHit, rdHit;
  logic ciEvt, awEvt, wdExp, tmrExp, msTick, intEvt;
  logic [5:0] tmrLen;

  always_comb
  begin
    wrHit = ce & regWr;
    rdHit = ce & regRd;
    tmrLen = timer_control_r[`SCIT_TMR_CNT_HI:0];
    // summaries are live levels: a source stays visible until its own register clears it
    top_irq_status[`SCIT_TOP_IRQ_STATUS_MOS] = monitorHandlerIrq;
    top_irq_status[`SCIT_TOP_IRQ_STATUS_CIC] = cmdIndChangeIrq;
    top_irq_status[`SCIT_TOP_IRQ_STATUS_TRAN] = tranIrq;
    top_irq_status[`SCIT_TOP_IRQ_STATUS_ST] = syncTransferIrq;
    top_irq_status[`SCIT_TOP_IRQ_STATUS_AUX] = |(auxStat_r & ~auxMask_r);
    ciEvt = (downstreamCmdInd != ciPrev_r) && (rss_r == `SCIT_RSS_CIAW);
    awEvt = !subscriberAwakeN && awakePrev_r && (rss_r == `SCIT_RSS_CIAW);
    wdExp = wdEn_r && (wdCnt_r == WDW'(WD_CYCLES - 1));
    msTick = (msPre_r == MSW'(MS_CYCLES - 1));
    tmrExp = msTick && (tmrLen != 6'h00) && !tmrDone_r && (msCnt_r == tmrLen - 6'h01);
    intEvt = ciEvt | awEvt | wdExp;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    mask_nxt = mask_r;
    auxStat_nxt = auxStat_r;
    auxMask_nxt = auxMask_r;
    rss_nxt = rss_r;
    soft_reset_reg_nxt = soft_reset_reg_r;
    sresCnt_nxt = sresCnt_r;
    polHigh_nxt = polHigh_r;
    ledSel_nxt = ledSel_r;
    ledBit_nxt = ledBit_r;
    timer_control_nxt = timer_control_r;
    msPre_nxt = msPre_r;
    msCnt_nxt = msCnt_r;
    tmrDone_nxt = tmrDone_r;
    wdEn_nxt = wdEn_r;
    wdCnt_nxt = wdCnt_r;
    wdSeq_nxt = wdSeq_r;
    pulse_nxt = pulse_r;
    pulseCnt_nxt = pulseCnt_r;
    ciPrev_nxt = downstreamCmdInd;
    awakePrev_nxt = subscriberAwakeN;
    rdData_nxt = rdData_r;

    // register reads; reading the aux status clears it
    if (rdHit)
    begin
      case (regAddr)
        `SCIT_ADR_MASK: rdData_nxt = {3'h0, mask_r};
        `SCIT_ADR_TOP_IRQ_STATUS: rdData_nxt = {3'h0, top_irq_status & ~mask_r};
        `SCIT_ADR_AUX_IRQ_STATUS: rdData_nxt = {6'h00, auxStat_r};
        `SCIT_ADR_AUX_IRQ_MASK: rdData_nxt = {6'h00, auxMask_r};
        `SCIT_ADR_FIRST_MODE_REG: rdData_nxt = {6'h00, rss_r};
        `SCIT_ADR_SOFT_RESET_REG: rdData_nxt = 8'(soft_reset_reg_r);
        `SCIT_ADR_CFG: rdData_nxt = {7'h00, polHigh_r};
        `SCIT_ADR_AUX_CONFIG_TWO: rdData_nxt = {6'h00, ledBit_r, ledSel_r};
        `SCIT_ADR_TIMER_CONTROL: rdData_nxt = timer_control_r;
        default: rdData_nxt = `SCIT_ZERO8;
      endcase
      if (regAddr == `SCIT_ADR_AUX_IRQ_STATUS)
        auxStat_nxt = 2'h0;
    end

    if (wrHit)
    begin
      case (regAddr)
        `SCIT_ADR_MASK: mask_nxt = regWrData[4:0];
        `SCIT_ADR_AUX_IRQ_MASK: auxMask_nxt = regWrData[1:0];
        `SCIT_ADR_FIRST_MODE_REG: rss_nxt = regWrData[1:0];
        `SCIT_ADR_SOFT_RESET_REG:
        begin
          soft_reset_reg_nxt = regWrData[SOFT_RESET_REG_W-1:0];
          sresCnt_nxt = 3'h0;
        end
        `SCIT_ADR_CFG: polHigh_nxt = regWrData[`SCIT_CFG_POL];
        `SCIT_ADR_AUX_CONFIG_TWO:
        begin
          ledSel_nxt = regWrData[`SCIT_AUX_CONFIG_TWO_SEL];
          ledBit_nxt = regWrData[`SCIT_AUX_CONFIG_TWO_LED];
        end
        `SCIT_ADR_TIMER_CONTROL:
        begin
          timer_control_nxt = regWrData;
          msPre_nxt = '0;
          msCnt_nxt = 6'h00;
          tmrDone_nxt = 1'b0;
        end
        `SCIT_ADR_WDOG:
        begin
          // only 1,0 followed directly by 0,1 restarts; anything else starts over
          case (wdSeq_r)
            WD_IDLE:
              if (regWrData[`SCIT_WD_A] && !regWrData[`SCIT_WD_B])
                wdSeq_nxt = WD_ARMED;
            WD_ARMED:
            begin
              wdSeq_nxt = WD_IDLE;
              if (!regWrData[`SCIT_WD_A] && regWrData[`SCIT_WD_B])
                wdCnt_nxt = '0;
            end
            default: wdSeq_nxt = WD_IDLE;
          endcase
        end
        default: ;
      endcase
    end

    // watchdog enable is sticky; a later mode write cannot clear it
    if (wrHit && regAddr == `SCIT_ADR_FIRST_MODE_REG && regWrData[1:0] == `SCIT_RSS_WDOG && !wdEn_r)
    begin
      wdEn_nxt = 1'b1;
      wdCnt_nxt = '0;
      wdSeq_nxt = WD_IDLE;
    end
    else if (wdEn_r && !(wrHit && regAddr == `SCIT_ADR_WDOG && wdSeq_r == WD_ARMED
                          && !regWrData[`SCIT_WD_A] && regWrData[`SCIT_WD_B]))
      wdCnt_nxt = wdExp ? '0 : wdCnt_r + 1'b1;

    // software reset bits self-clear after four bit clocks
    if (soft_reset_reg_r != '0 && bitClkEn && !(wrHit && regAddr == `SCIT_ADR_SOFT_RESET_REG))
    begin
      sresCnt_nxt = sresCnt_r + 3'h1;
      if (sresCnt_r == `SCIT_SOFT_RESET_REG_BCL_CYCLES - 3'h1)
      begin
        soft_reset_reg_nxt = '0;
        sresCnt_nxt = 3'h0;
      end
    end

    // millisecond timer; count field zero keeps it stopped
    if (tmrLen != 6'h00 && !tmrDone_r && !(wrHit && regAddr == `SCIT_ADR_TIMER_CONTROL))
    begin
      msPre_nxt = msTick ? '0 : msPre_r + 1'b1;
      if (msTick)
        msCnt_nxt = tmrExp ? 6'h00 : msCnt_r + 6'h01;
      if (tmrExp && !timer_control_r[`SCIT_TMR_MODE])
        tmrDone_nxt = 1'b1;
    end

    // hardware sets win over the clear-on-read above
    if (tmrExp)
      auxStat_nxt[`SCIT_AUX_TIN] = 1'b1;
    if (wdExp)
      auxStat_nxt[`SCIT_AUX_WOV] = 1'b1;

    // an internal source event also overrides a mode write in the same cycle
    if (intEvt)
      rss_nxt = `SCIT_FIRST_MODE_REG_RST;

    // reset pulse: 125 us, inside the allowed 125 to 250 us window
    case (pulse_r)
      PULSE_IDLE:
        if (intEvt)
        begin
          pulse_nxt = PULSE_ACTIVE;
          pulseCnt_nxt = '0;
        end
      PULSE_ACTIVE:
      begin
        pulseCnt_nxt = pulseCnt_r + 1'b1;
        if (pulseCnt_r == PW'(PULSE_CYCLES - 1))
          pulse_nxt = PULSE_IDLE;
      end
      default: pulse_nxt = PULSE_IDLE;
    endcase

    // outputs
    irq_nxt = (|(top_irq_status & ~mask_r)) ^ ~polHigh_r;
    // soft external reset reaches the pin for every field value, internal ones only via pulse
    rstOut_nxt = !(pulse_r == PULSE_ACTIVE || soft_reset_reg_r[`SCIT_SOFT_RESET_REG_EXT]);
    led_nxt = ledSel_r ? !ledBit_r : !layer1Activated;
    wake_nxt = !subscriberAwakeN;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers; reset output starts asserted low, interrupt starts inactive high
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_r <= `SCIT_MASK_RST;
      auxStat_r <= 2'h0;
      auxMask_r <= `SCIT_AUX_IRQ_MASK_RST;
      rss_r <= `SCIT_FIRST_MODE_REG_RST;
      soft_reset_reg_r <= '0;
      sresCnt_r <= 3'h0;
      polHigh_r <= 1'b0;
      ledSel_r <= 1'b0;
      ledBit_r <= 1'b0;
      timer_control_r <= `SCIT_TIMER_CONTROL_RST;
      msPre_r <= '0;
      msCnt_r <= 6'h00;
      tmrDone_r <= 1'b0;
      wdEn_r <= 1'b0;
      wdCnt_r <= '0;
      wdSeq_r <= WD_IDLE;
      pulse_r <= PULSE_IDLE;
      pulseCnt_r <= '0;
      ciPrev_r <= 4'h0;
      awakePrev_r <= 1'b1;
      rdData_r <= `SCIT_ZERO8;
      irq_r <= 1'b1;
      rstOut_r <= 1'b0;
      led_r <= 1'b1;
      wake_r <= 1'b0;
    end
    else if (ce)
    begin
      mask_r <= mask_nxt;
      auxStat_r <= auxStat_nxt;
      auxMask_r <= auxMask_nxt;
      rss_r <= rss_nxt;
      soft_reset_reg_r <= soft_reset_reg_nxt;
      sresCnt_r <= sresCnt_nxt;
      polHigh_r <= polHigh_nxt;
      ledSel_r <= ledSel_nxt;
      ledBit_r <= ledBit_nxt;
      timer_control_r <= timer_control_nxt;
      msPre_r <= msPre_nxt;
      msCnt_r <= msCnt_nxt;
      tmrDone_r <= tmrDone_nxt;
      wdEn_r <= wdEn_nxt;
      wdCnt_r <= wdCnt_nxt;
      wdSeq_r <= wdSeq_nxt;
      pulse_r <= pulse_nxt;
      pulseCnt_r <= pulseCnt_nxt;
      ciPrev_r <= ciPrev_nxt;
      awakePrev_r <= awakePrev_nxt;
      rdData_r <= rdData_nxt;
      irq_r <= irq_nxt;
      rstOut_r <= rstOut_nxt;
      led_r <= led_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign irqOut = irq_r;
  assign resetOutN = rstOut_r;
  assign blockReset = soft_reset_reg_r;
  assign oscWake = wake_r;
  assign activationLedN = led_r;

endmodule

// File: bench/scit_sys_ctrl_asserts.sv
/* checker of the system control unit ports.
   assumes helper copies of the host registers that freeze with ce as the unit does. */
`timescale 1ns/1ns
module scit_sys_ctrl_asserts #(
  parameter int PULSE_CYCLES = 5
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic bitClkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic monitorHandlerIrq,
  input wire logic cmdIndChangeIrq,
  input wire logic tranIrq,
  input wire logic syncTransferIrq,
  input wire logic [3:0] downstreamCmdInd,
  input wire logic subscriberAwakeN,
  input wire logic layer1Activated,
  input wire logic irqOut,
  input wire logic resetOutN,
  input wire logic [3:0] blockReset,
  input wire logic oscWake,
  input wire logic activationLedN
);
  logic [4:0] maskR;
  logic [1:0] ledR;
  logic [1:0] modeR;
  logic polR;
  logic [2:0] bcR;
  int lowR;
  wire [3:0] src = {syncTransferIrq, tranIrq, cmdIndChangeIrq, monitorHandlerIrq};
  // mode copy drops to zero on a code change or awake fall in mode 2, as the unit does
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      maskR <= 5'h00;
      ledR <= 2'h0;
      modeR <= 2'h0;
      polR <= 1'b0;
      bcR <= 3'h0;
      lowR <= 0;
    end
    else if (ce)
    begin
      if (regWr && regAddr == 8'h20) maskR <= regWrData[4:0];
      if (regWr && regAddr == 8'h28) ledR <= regWrData[1:0];
      if (regWr && regAddr == 8'h27) polR <= regWrData[0];
      if (regWr && regAddr == 8'h24) modeR <= regWrData[1:0];
      else if (modeR == 2'h2 && ($changed(downstreamCmdInd) || $fell(subscriberAwakeN)))
        modeR <= 2'h0;
      bcR <= (blockReset == 4'h0) ? 3'h0 : bcR + {2'h0, bitClkEn};
      lowR <= resetOutN ? 0 : lowR + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // polarity acts one cycle late on the pin, like the mask
  a_irq_pend: assert property ((src & ~maskR[3:0]) != 4'h0 |=> irqOut == $past(polR))
    else $error("irq inactive with a pending source");
  a_irq_masked: assert property (maskR == 5'h1f |=> irqOut == !$past(polR))
    else $error("irq active with all masked");
  a_soft_reset_reg_len: assert property (blockReset != 4'h0 |-> bcR <= 3'h3)
    else $error("soft reset held too long");
  a_soft_reset_reg_out: assert property (blockReset[0] |-> ##[0:1] !resetOutN)
    else $error("soft reset not on reset output");
  // the low count trails the pin by one edge and the pin trails the soft bit by one more
  a_pulse_max: assert property (lowR > PULSE_CYCLES |-> $past(blockReset[0], 2))
    else $error("reset pulse too long");
  a_ci_pulse: assert property (modeR == 2'h2 && $changed(downstreamCmdInd) |-> ##[1:3] !resetOutN)
    else $error("no pulse on code change");
  a_rss_quiet: assert property (!modeR[1] && $changed(downstreamCmdInd)
    |=> (resetOutN || blockReset[0])[*4])
    else $error("unselected source reset");
  a_led_auto: assert property (!ledR[0] && layer1Activated |=> !activationLedN)
    else $error("led not on when activated");
  a_led_host: assert property (ledR[0] |=> activationLedN == !$past(ledR[1]))
    else $error("led not host driven");
  a_osc_wake: assert property (!subscriberAwakeN |=> oscWake)
    else $error("no wake on awake low");
endmodule

bind scit_sys_ctrl scit_sys_ctrl_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.*);

// File: bench/scit_host_model.sv
/* host side of the register port: one byte per request.
   assumes calls only after reset release. */
`timescale 1ns/1ns
module scit_host_model (
  input wire logic clock,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // released lines show the inverse so a stale value is never trusted
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= w;
    regRd <= !w;
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
endmodule

// File: bench/scit_sys_ctrl_test.sv
/* self-checking bench of the system control unit.
   assumes short counts: 10 cycles a ms, 5 cycle pulse, 200 cycle watchdog. */
`timescale 1ns/1ns
module scit_sys_ctrl_test;
  import scit_pkg::*;
  typedef struct {int sel; logic [31:0] val;} scit_note_t;
  scit_note_t notes[$];
  scit_note_t n;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic bitClkEn = 1'b0;
  logic [3:0] src = 4'h0;
  logic [3:0] ci = 4'h0;
  logic awakeN = 1'b1;
  logic l1 = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWr, regRd, irqOut, resetOutN, oscWake, ledN;
  logic [3:0] blockReset;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'ha4ca;
  int lowCnt = 0;
  int div = 0;
  int snap, k;
  always #4 clock = ~clock;
  // bit clock strobe every fourth cycle; low cycles of the reset output counted
  always @(posedge clock)
  begin
    div <= div + 1;
    bitClkEn <= (div[1:0] == 2'h0);
    lowCnt <= lowCnt + (resetOutN === 1'b0);
  end
  scit_host_model host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd));
  scit_sys_ctrl #(.MS_CYCLES(10), .PULSE_CYCLES(5), .WD_CYCLES(200)) dut (
    .clock(clock), .rstn(rstn), .ce(ce), .bitClkEn(bitClkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .monitorHandlerIrq(src[0]), .cmdIndChangeIrq(src[1]), .tranIrq(src[2]),
    .syncTransferIrq(src[3]), .downstreamCmdInd(ci), .subscriberAwakeN(awakeN),
    .layer1Activated(l1), .irqOut(irqOut), .resetOutN(resetOutN),
    .blockReset(blockReset), .oscWake(oscWake), .activationLedN(ledN));
`define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: sel %0d got %h", $time, n.sel, a); end end
  function automatic logic [31:0] act(int s);
    case (s)
      0: return {24'h0, regRdData};
      1: return {31'h0, irqOut};
      2: return lowCnt;
      3: return {31'h0, resetOutN};
      4: return {28'h0, blockReset};
      5: return {31'h0, oscWake};
      default: return {31'h0, ledN};
    endcase
  endfunction
  always @(negedge clock)
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      `CMP(act(n.sel), n.val)
    end
  task note(int s, logic [31:0] v);
    notes.push_back('{s, v});
  endtask
  task cyc(int c);
    repeat (c) @(posedge clock);
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    host.xfer(a, d, 1'b1);
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    host.xfer(a, 8'h00, 1'b0);
    note(0, e);
  endtask
  task test_done;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    test_done();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(2);
    rstn <= 1'b1;
    cyc(2);
    note(1, 1);
    note(3, 1);
    note(6, 0);
    rd(8'h20, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h65, 8'h00);
    rd(8'h30, 8'h00);
    // a write while ce is low must not land
    ce <= 1'b0;
    wr(8'h20, 8'h1f);
    ce <= 1'b1;
    rd(8'h20, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      src <= 4'h1 << i;
      cyc(2);
      note(1, 0);
      rd(8'h21, 8'h01 << i);
      wr(8'h20, 8'h01 << i);
      cyc(2);
      note(1, 1);
      wr(8'h20, 8'h00);
    end
    wr(8'h27, 8'h01);
    cyc(2);
    note(1, 1);
    wr(8'h20, 8'h1f);
    cyc(2);
    note(1, 0);
    wr(8'h20, 8'h00);
    wr(8'h27, 8'h00);
    src <= 4'h0;
    cyc(2);
    note(1, 1);
    $display("irq test done");
    wr(8'h65, 8'h02);
    cyc(25);
    note(1, 0);
    rd(8'h21, 8'h10);
    rd(8'h22, 8'h01);
    cyc(2);
    note(1, 1);
    cyc(30);
    rd(8'h22, 8'h00);
    k = ($random(seed) & 3) + 1;
    wr(8'h65, 8'h80 | k[7:0]);
    cyc(k * 10 + 4);
    rd(8'h22, 8'h01);
    // the second expiry lands before this read and the stop before the third, so nothing is pending after it
    cyc(k * 10 - 2);
    rd(8'h22, 8'h01);
    wr(8'h65, 8'h00);
    rd(8'h22, 8'h00);
    cyc(30);
    rd(8'h22, 8'h00);
    wr(8'h23, 8'h01);
    wr(8'h65, 8'h01);
    cyc(15);
    note(1, 1);
    wr(8'h65, 8'h00);
    rd(8'h22, 8'h01);
    wr(8'h23, 8'h00);
    $display("timer test done");
    snap = lowCnt;
    wr(8'h24, 8'h02);
    ci <= ci ^ (4'h1 | 4'($random(seed)));
    cyc(12);
    note(2, snap + 5);
    rd(8'h24, 8'h00);
    snap = lowCnt;
    wr(8'h24, 8'h02);
    awakeN <= 1'b0;
    cyc(2);
    note(5, 1);
    cyc(10);
    note(2, snap + 5);
    awakeN <= 1'b1;
    rd(8'h24, 8'h00);
    wr(8'h24, 8'h01);
    snap = lowCnt;
    ci <= ci ^ 4'h1;
    cyc(10);
    note(2, snap);
    wr(8'h25, 8'h0f);
    cyc(2);
    note(4, 4'hf);
    note(3, 0);
    cyc(20);
    note(4, 0);
    note(3, 1);
    $display("reset source test done");
    snap = lowCnt;
    wr(8'h24, 8'h03);
    repeat (3)
    begin
      cyc(150);
      wr(8'h26, 8'h02);
      wr(8'h26, 8'h01);
    end
    note(2, snap);
    cyc(100);
    wr(8'h26, 8'h01);
    wr(8'h26, 8'h02);
    cyc(110);
    note(2, snap + 5);
    rd(8'h22, 8'h02);
    rd(8'h24, 8'h00);
    wr(8'h24, 8'h00);
    snap = lowCnt;
    cyc(210);
    note(2, snap + 5);
    rstn <= 1'b0;
    cyc(1);
    note(3, 0);
    rstn <= 1'b1;
    rd(8'h22, 8'h00);
    snap = lowCnt;
    cyc(210);
    note(2, snap);
    $display("watchdog test done");
    l1 <= 1'b0;
    cyc(2);
    note(6, 1);
    wr(8'h28, 8'h01);
    cyc(2);
    note(6, 1);
    wr(8'h28, 8'h03);
    cyc(2);
    note(6, 0);
    $display("led test done");
    cyc(2);
    test_done();
  end
endmodule
